/* File: rtl/ajc_jog_command_block.sv */
/*
  ajc_jog_command_block: level-active jog controller for one axis, with
  profile generator, sticky interrupt status and a plain register port.
  assumes command inputs come from logic on clk; limit pins are async.
*/
// Local design decisions: the placing of the registers and the address-and-strobe port.
// Function
// - the axis number (0 to 71) is caught on the enable rising edge and kept.
// - an axis number change while in continuous run puts the held axis in fault halt.
// - an axis number change while disabled waits for the next rise.
// - the rise catches velocity, rates and curve and, with axis power and a valid axis, enters continuous run.
// - a halt or relative move while in continuous run ends the jog and sets aborted.
// - a positive request moves up at held velocity, a negative one down.
// - both requests at once stop the axis with error but no fault halt.
// - a limit ahead stops the axis with error; a retrigger allows reverse.
// - curve select 0 ramps speed linearly with the held rates.
// - curve select 1 ramps the rate itself up to the held rates as peaks.
// - enable with axis power and an axis number up to 71 puts the axis in continuous run and raises busy.
// - direction requests act by level, motion ends when a request drops.
`timescale 1ns/1ps
module ajc_jog_command_block #(
  parameter int unsigned VEL_W    = 16,
  parameter int unsigned TICK_DIV = ajc_pkg::TICK_DIV,
  parameter int unsigned JERK     = 1
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              enable,
  input  wire logic [6:0]        axis_number,
  input  wire logic              profile_curve_select,
  input  wire logic [VEL_W-1:0]  velocity,
  input  wire logic [VEL_W-1:0]  acceleration,
  input  wire logic [VEL_W-1:0]  deceleration,
  input  wire logic              positive_direction_request,
  input  wire logic              negative_direction_request,
  input  wire logic              halt_command,
  input  wire logic              relative_move_command,
  input  wire logic              axis_enable_command,
  input  wire logic              limit_pos_pin,
  input  wire logic              limit_neg_pin,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  output logic                   busy,
  output logic                   aborted,
  output logic                   error,
  output logic [15:0]            failure_code,
  output logic                   fault_halt,
  output logic [6:0]             axis_sel,
  output logic [VEL_W-1:0]       speed_mag,
  output logic                   speed_neg,
  output logic                   irq
);
  ajc_pkg::ajc_state_t state_ff;
  logic                en_d_ff, curve_ff, busy_ff, aborted_ff, error_ff;
  logic                fhalt_ff, dir_ff, tick_ff, irq_ff;
  logic [6:0]          axis_ff;
  logic [VEL_W-1:0]    vel_ff, acc_ff, dec_ff, sp_ff, rate_ff;
  logic [15:0]         code_ff;
  logic [31:0]         div_ff, rdata_ff;
  logic [1:0]          lim_s1_ff, lim_s2_ff, lim_s3_ff, lim_ff;
  logic [3:0]          status_ff, mask_ff;
  logic                en_rise, run_en, axis_chg, abort_req, both_req;
  logic                lim_hit, tgt_dir, decel_c;
  logic [VEL_W-1:0]    tgt_mag, lim_rate, step_c, gap_c;
  logic [3:0]          ev_set;

  assign en_rise   = enable & ~en_d_ff;
  assign run_en    = (state_ff == ajc_pkg::ST_RUN) & enable & ~en_rise;
  assign axis_chg  = run_en & (axis_number != axis_ff);
  assign abort_req = run_en & (halt_command | relative_move_command);
  assign both_req  = run_en & positive_direction_request
                   & negative_direction_request;
  // limit only counts against the direction actually being driven
  assign lim_hit   = run_en & (sp_ff != '0)
                   & (dir_ff ? lim_ff[1] : lim_ff[0]);

  // target follows request levels; no request means zero speed
  always_comb begin
    tgt_mag = '0;
    tgt_dir = dir_ff;
    if (state_ff == ajc_pkg::ST_RUN && enable) begin
      if (positive_direction_request && !negative_direction_request) begin
        tgt_mag = vel_ff;
        tgt_dir = 1'b0;
      end else if (negative_direction_request
                   && !positive_direction_request) begin
        tgt_mag = vel_ff;
        tgt_dir = 1'b1;
      end
    end
  end

  // reversing always passes through zero speed first
  always_comb begin
    decel_c  = (tgt_dir != dir_ff && sp_ff != '0) || (tgt_mag < sp_ff);
    lim_rate = decel_c ? dec_ff : acc_ff;
    step_c   = curve_ff ? rate_ff : lim_rate;
    if (decel_c) begin
      gap_c = (tgt_dir != dir_ff) ? sp_ff : sp_ff - tgt_mag;
    end else begin
      gap_c = tgt_mag - sp_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff  <= '0;
      tick_ff <= 1'b0;
    end else if (div_ff == TICK_DIV - 1) begin
      div_ff  <= '0;
      tick_ff <= 1'b1;
    end else begin
      div_ff  <= div_ff + 32'h1;
      tick_ff <= 1'b0;
    end
  end

  // second and third stage must agree before a limit change is taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lim_s1_ff <= 2'h0;
      lim_s2_ff <= 2'h0;
      lim_s3_ff <= 2'h0;
      lim_ff    <= 2'h0;
    end else begin
      lim_s1_ff <= {limit_neg_pin, limit_pos_pin};
      lim_s2_ff <= lim_s1_ff;
      lim_s3_ff <= lim_s2_ff;
      if (lim_s2_ff == lim_s3_ff) begin
        lim_ff <= lim_s3_ff;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_d_ff  <= 1'b0;
      axis_ff  <= 7'h00;
      vel_ff   <= '0;
      acc_ff   <= '0;
      dec_ff   <= '0;
      curve_ff <= 1'b0;
    end else begin
      en_d_ff <= enable;
      if (en_rise) begin
        axis_ff  <= axis_number;
        vel_ff   <= velocity;
        acc_ff   <= acceleration;
        dec_ff   <= deceleration;
        curve_ff <= profile_curve_select;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= ajc_pkg::ST_STANDSTILL;
      busy_ff    <= 1'b0;
      aborted_ff <= 1'b0;
      error_ff   <= 1'b0;
      code_ff    <= ajc_pkg::CODE_NONE;
      fhalt_ff   <= 1'b0;
    end else if (en_rise) begin
      aborted_ff <= 1'b0;
      fhalt_ff   <= 1'b0;
      if (axis_number > ajc_pkg::AXIS_MAX) begin
        state_ff <= ajc_pkg::ST_HALTED;
        busy_ff  <= 1'b0;
        error_ff <= 1'b1;
        code_ff  <= ajc_pkg::CODE_RANGE;
      end else if (!axis_enable_command) begin
        // guards against a program that skips enabling the axis
        state_ff <= ajc_pkg::ST_HALTED;
        busy_ff  <= 1'b0;
        error_ff <= 1'b1;
        code_ff  <= ajc_pkg::CODE_NOPWR;
      end else begin
        state_ff <= ajc_pkg::ST_RUN;
        busy_ff  <= 1'b1;
        error_ff <= 1'b0;
        code_ff  <= ajc_pkg::CODE_NONE;
      end
    end else if (axis_chg) begin
      state_ff <= ajc_pkg::ST_FAULT_HALT;
      fhalt_ff <= 1'b1;
      busy_ff  <= 1'b0;
      error_ff <= 1'b1;
      code_ff  <= ajc_pkg::CODE_AXIS;
    end else if (abort_req) begin
      // the taking command owns the axis from here on
      state_ff   <= ajc_pkg::ST_HALTED;
      busy_ff    <= 1'b0;
      aborted_ff <= 1'b1;
    end else if (both_req) begin
      state_ff <= ajc_pkg::ST_HALTED;
      busy_ff  <= 1'b0;
      error_ff <= 1'b1;
      code_ff  <= ajc_pkg::CODE_BOTH;
    end else if (lim_hit) begin
      state_ff <= ajc_pkg::ST_HALTED;
      busy_ff  <= 1'b0;
      error_ff <= 1'b1;
      code_ff  <= ajc_pkg::CODE_LIMIT;
    end else if (state_ff == ajc_pkg::ST_RUN && !enable) begin
      state_ff <= ajc_pkg::ST_STOPPING;
    end else if (state_ff == ajc_pkg::ST_STOPPING && sp_ff == '0) begin
      state_ff <= ajc_pkg::ST_STANDSTILL;
      busy_ff  <= 1'b0;
    end else if (state_ff == ajc_pkg::ST_HALTED && !enable
                 && sp_ff == '0) begin
      state_ff <= ajc_pkg::ST_STANDSTILL;
    end
  end

  // speed profile, one step per tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_ff   <= '0;
      dir_ff  <= 1'b0;
      rate_ff <= '0;
    end else if (tick_ff) begin
      if (sp_ff == '0) begin
        dir_ff <= tgt_dir;
      end
      if (gap_c == '0) begin
        rate_ff <= '0;
      end else begin
        if (gap_c <= step_c) begin
          sp_ff   <= decel_c ? sp_ff - gap_c : sp_ff + gap_c;
          rate_ff <= '0;
        end else begin
          sp_ff <= decel_c ? sp_ff - step_c : sp_ff + step_c;
        end
        // rate grows toward its peak; trades exact S shape for area
        if (gap_c > step_c && rate_ff < lim_rate) begin
          rate_ff <= ((lim_rate - rate_ff) > VEL_W'(JERK))
                   ? rate_ff + VEL_W'(JERK) : lim_rate;
        end
      end
    end
  end

  assign ev_set = {
    (state_ff == ajc_pkg::ST_STOPPING && sp_ff == '0 && !en_rise),
    lim_hit & ~axis_chg & ~abort_req & ~both_req,
    (axis_chg | both_req | lim_hit) & ~abort_req | (axis_chg & abort_req),
    abort_req & ~axis_chg
  };

  // set beats the clear of a status read in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= 4'h0;
      mask_ff   <= ajc_pkg::MASK_RESET;
      irq_ff    <= 1'b0;
      rdata_ff  <= 32'h0;
    end else begin
      if (reg_rd && reg_addr == ajc_pkg::OFS_STATUS) begin
        status_ff <= ev_set;
      end else begin
        status_ff <= status_ff | ev_set;
      end
      if (reg_wr && reg_addr == ajc_pkg::OFS_MASK) begin
        mask_ff <= reg_wdata[3:0];
      end
      irq_ff <= |(status_ff & mask_ff);
      rdata_ff <= 32'h0;
      if (reg_rd) begin
        if (reg_addr == ajc_pkg::OFS_STATUS) begin
          rdata_ff <= {28'h0, status_ff};
        end else if (reg_addr == ajc_pkg::OFS_MASK) begin
          rdata_ff <= {28'h0, mask_ff};
        end else if (reg_addr == ajc_pkg::OFS_STATE) begin
          rdata_ff <= {16'h0, 1'b0, axis_ff, 1'b0, lim_ff,
                       fhalt_ff, busy_ff, state_ff};
        end else if (reg_addr == ajc_pkg::OFS_CODE) begin
          rdata_ff <= {16'h0, code_ff};
        end
      end
    end
  end

  assign reg_rdata    = rdata_ff;
  assign busy         = busy_ff;
  assign aborted      = aborted_ff;
  assign error        = error_ff;
  assign failure_code = code_ff;
  assign fault_halt   = fhalt_ff;
  assign axis_sel     = axis_ff;
  assign speed_mag    = sp_ff;
  assign speed_neg    = dir_ff;
  assign irq          = irq_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_AXIS_LATCH: assert property (
    en_rise |=> axis_ff == $past(axis_number))
    else $error("axis not caught on enable rise");
  AST_AXIS_HOLD: assert property (
    !en_rise |=> $stable(axis_ff))
    else $error("axis changed without enable rise");
  AST_AXIS_CHG: assert property (
    axis_chg |=> state_ff == ajc_pkg::ST_FAULT_HALT && fhalt_ff
                 && code_ff == ajc_pkg::CODE_AXIS)
    else $error("axis change did not fault halt");
  AST_ABORT: assert property (
    abort_req && !axis_chg |=> aborted_ff && !busy_ff)
    else $error("abort not reported");
  AST_BOTH: assert property (
    both_req && !axis_chg && !abort_req
    |=> error_ff && !fhalt_ff && state_ff == ajc_pkg::ST_HALTED)
    else $error("conflicting requests mishandled");
  AST_START: assert property (
    en_rise && axis_enable_command && axis_number <= ajc_pkg::AXIS_MAX
    |=> busy_ff && state_ff == ajc_pkg::ST_RUN && !aborted_ff && !error_ff)
    else $error("enable rise did not start run");
  AST_TRAP: assert property (
    tick_ff && !curve_ff && !decel_c && gap_c > step_c
    |=> sp_ff == $past(sp_ff) + $past(acc_ff))
    else $error("linear ramp step wrong");
  AST_REST: assert property (
    state_ff == ajc_pkg::ST_STOPPING && sp_ff == '0 && !enable
    |=> state_ff == ajc_pkg::ST_STANDSTILL && !busy_ff)
    else $error("stop did not reach standstill");
  AST_IRQ: assert property (
    ##1 irq_ff == |($past(status_ff) & $past(mask_ff)))
    else $error("interrupt level wrong");

  CVR_RUN:   cover property (en_rise ##1 state_ff == ajc_pkg::ST_RUN);
  CVR_ABORT: cover property (abort_req ##1 aborted_ff);
  CVR_BOTH:  cover property (both_req ##1 error_ff);
  CVR_LIMIT: cover property (lim_hit ##1 code_ff == ajc_pkg::CODE_LIMIT);
endmodule // ajc_jog_command_block

/* File: pkg/ajc_pkg.sv */
/*
  ajc_pkg: constants shared by the jog command controller.
  assumes one 25 MHz clock; offsets are byte addresses of 32-bit words.
*/
package ajc_pkg;
  localparam int unsigned CLK_HZ       = 25_000_000;
  // profile update rate
  localparam int unsigned TICK_HZ      = 1_000;
  localparam int unsigned TICK_DIV     = CLK_HZ / TICK_HZ;
  localparam logic [6:0]  AXIS_MAX     = 7'h47;

  localparam logic [3:0]  OFS_STATUS   = 4'h0;
  localparam logic [3:0]  OFS_MASK     = 4'h4;
  localparam logic [3:0]  OFS_STATE    = 4'h8;
  localparam logic [3:0]  OFS_CODE     = 4'hc;

  localparam int unsigned IRQ_W        = 4;
  localparam int unsigned BIT_ABORT    = 0;
  localparam int unsigned BIT_ERROR    = 1;
  localparam int unsigned BIT_LIMIT    = 2;
  localparam int unsigned BIT_REST     = 3;
  localparam logic [3:0]  MASK_RESET   = 4'h0;

  localparam logic [15:0] CODE_NONE    = 16'h0000;
  localparam logic [15:0] CODE_AXIS    = 16'h0001;
  localparam logic [15:0] CODE_BOTH    = 16'h0002;
  localparam logic [15:0] CODE_LIMIT   = 16'h0003;
  localparam logic [15:0] CODE_NOPWR   = 16'h0004;
  localparam logic [15:0] CODE_RANGE   = 16'h0005;

  typedef enum logic [2:0] {
    ST_STANDSTILL = 3'b000,
    ST_RUN        = 3'b001,
    ST_STOPPING   = 3'b010,
    ST_FAULT_HALT = 3'b011,
    ST_HALTED     = 3'b100
  } ajc_state_t;
endpackage

/* File: tb/ajc_axis_model.sv */
/*
  ajc_axis_model: far-side axis with its power stage and travel limits.
  assumes speed_mag is units per clk cycle and travel starts at zero.
*/
`timescale 1ns/1ps
module ajc_axis_model #(
  parameter int LIM = 6000
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        power_req,
  input  wire logic [15:0] speed_mag,
  input  wire logic        speed_neg,
  output logic             axis_enable_command,
  output logic             limit_pos_pin,
  output logic             limit_neg_pin
);
  int pos_ff;

  // power stage answers a cycle late, as a real drive enable would
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      axis_enable_command <= 1'b0;
    else
      axis_enable_command <= power_req;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      pos_ff <= 0;
    else if (speed_neg)
      pos_ff <= pos_ff - int'(speed_mag);
    else
      pos_ff <= pos_ff + int'(speed_mag);
  end

  // switch stays closed while the carriage sits past it
  assign limit_pos_pin = (pos_ff >= LIM);
  assign limit_neg_pin = (pos_ff <= -LIM);
endmodule // ajc_axis_model

/* File: tb/ajc_jog_command_block_test.sv */
/*
  ajc_jog_command_block_test: directed bench for the jog controller.
  assumes ajc_pkg is compiled first and the profile tick is cut to 4.
*/
`timescale 1ns/1ps
module ajc_jog_command_block_test;
  localparam logic [15:0] VEL = 16'h0014;
  localparam logic [15:0] ACC = 16'h0008;
  logic        clk, rst_n, enable, curve, pos_rq, neg_rq, halt, rel, pwr;
  logic        aec, lim_p, lim_n, reg_wr, reg_rd;
  logic [6:0]  axis_number, axis_sel;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic        busy, aborted, error, fault_halt, speed_neg, irq;
  logic [15:0] failure_code, speed_mag, vel;
  int          bad_count, tests_run, i;

  ajc_jog_command_block #(.TICK_DIV(4)) u_ajc_jog_command_block (
    .clk(clk), .rst_n(rst_n), .enable(enable), .axis_number(axis_number),
    .profile_curve_select(curve), .velocity(vel), .acceleration(ACC),
    .deceleration(16'h0006), .positive_direction_request(pos_rq),
    .negative_direction_request(neg_rq), .halt_command(halt),
    .relative_move_command(rel), .axis_enable_command(aec),
    .limit_pos_pin(lim_p), .limit_neg_pin(lim_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .busy(busy), .aborted(aborted), .error(error),
    .failure_code(failure_code), .fault_halt(fault_halt),
    .axis_sel(axis_sel), .speed_mag(speed_mag), .speed_neg(speed_neg),
    .irq(irq));
  ajc_axis_model u_ajc_axis_model (.clk(clk), .rst_n(rst_n),
    .power_req(pwr), .speed_mag(speed_mag), .speed_neg(speed_neg),
    .axis_enable_command(aec), .limit_pos_pin(lim_p),
    .limit_neg_pin(lim_n));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      bad_count++;
    end
  endtask

  task automatic look(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // k: 0 idle, 1 speed equals v, 2 moving, 3 error raised
  task automatic wait_on(input int k, input logic [15:0] v);
    int n;
    n = 0;
    while (!((k == 0 && busy === 1'b0) || (k == 1 && speed_mag === v) ||
             (k == 2 && speed_mag !== 16'h0) || (k == 3 && error === 1'b1))
          ) begin
      look(1);
      n++;
      if (n > 3000) begin
        $display("ERROR t=%0t wait=%h value=%h", $time, k, v);
        bad_count++;
        test_done();
      end
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic start(input logic [6:0] ax, input logic c);
    @(posedge clk);
    axis_number <= ax;
    curve <= c;
    @(posedge clk);
    enable <= 1'b1;
    look(3);
  endtask

  task automatic stop();
    @(posedge clk);
    enable <= 1'b0;
    pos_rq <= 1'b0;
    neg_rq <= 1'b0;
    halt <= 1'b0;
    rel <= 1'b0;
    vel <= VEL;
    look(1);
    wait_on(0, 16'h0);
  endtask

  task automatic t_refuse();
    start(7'h00, 1'b0);
    chk(busy, 1'b0);
    chk(failure_code, ajc_pkg::CODE_NOPWR);
    stop();
    @(posedge clk);
    pwr <= 1'b1;
    look(2);
    start(7'h48, 1'b0);
    chk({busy, error}, 2'b01);
    chk(failure_code, ajc_pkg::CODE_RANGE);
    stop();
    $display("test refuse done");
  endtask

  task automatic t_run(input logic c);
    start(7'h05, c);
    chk({busy, axis_sel, speed_mag}, {1'b1, 7'h05, 16'h0});
    @(posedge clk);
    pos_rq <= 1'b1;
    // a change after the rise must not reach the profile
    vel <= 16'h0030;
    wait_on(2, 16'h0);
    if (c)
      chk(speed_mag < ACC, 1'b1);
    else
      chk(speed_mag, ACC);
    wait_on(1, VEL);
    look(12);
    chk(speed_mag, VEL);
    chk(speed_neg, 1'b0);
    @(posedge clk);
    pos_rq <= 1'b0;
    wait_on(1, 16'h0);
    chk(busy, 1'b1);
    @(posedge clk);
    neg_rq <= 1'b1;
    wait_on(1, VEL);
    chk(speed_neg, 1'b1);
    stop();
    chk(speed_mag, 16'h0);
    rd(ajc_pkg::OFS_STATUS, d);
    chk(d[ajc_pkg::BIT_REST], 1'b1);
    rd(ajc_pkg::OFS_STATUS, d);
    chk(d, 32'h0);
    $display("test run curve %0d done", c);
  endtask

  task automatic t_both();
    start(7'h05, 1'b0);
    @(posedge clk);
    pos_rq <= 1'b1;
    neg_rq <= 1'b1;
    look(6);
    chk({error, fault_halt, speed_mag}, {2'b10, 16'h0});
    chk(failure_code, ajc_pkg::CODE_BOTH);
    stop();
    chk({error, failure_code}, {1'b1, ajc_pkg::CODE_BOTH});
    start(7'h05, 1'b0);
    chk({error, failure_code}, {1'b0, ajc_pkg::CODE_NONE});
    stop();
    $display("test both done");
  endtask

  task automatic t_abort();
    rd(ajc_pkg::OFS_STATUS, d);
    rd(4'h2, d);
    chk(d, 32'h0);
    for (i = 0; i < 2; i++) begin
      wr(ajc_pkg::OFS_MASK, (i == 0) ? 32'h1 : 32'h0);
      rd(ajc_pkg::OFS_MASK, d);
      chk(d, (i == 0) ? 32'h1 : 32'h0);
      start(7'h02, 1'b0);
      @(posedge clk);
      if (i == 0)
        halt <= 1'b1;
      else
        rel <= 1'b1;
      look(4);
      chk({aborted, irq}, {1'b1, (i == 0)});
      rd(ajc_pkg::OFS_STATUS, d);
      chk(d[ajc_pkg::BIT_ABORT], 1'b1);
      look(2);
      chk(irq, 1'b0);
      stop();
    end
    $display("test abort done");
  endtask

  task automatic t_axis();
    start(7'h03, 1'b0);
    @(posedge clk);
    axis_number <= 7'h09;
    look(4);
    chk({fault_halt, axis_sel}, {1'b1, 7'h03});
    chk(failure_code, ajc_pkg::CODE_AXIS);
    rd(ajc_pkg::OFS_CODE, d);
    chk(d, {16'h0, ajc_pkg::CODE_AXIS});
    // axis 3, fault halt bit, state code of fault halt
    rd(ajc_pkg::OFS_STATE, d);
    chk(d, 32'h0000_0313);
    stop();
    @(posedge clk);
    axis_number <= 7'h07;
    look(3);
    chk(axis_sel, 7'h03);
    start(7'h07, 1'b0);
    chk({fault_halt, axis_sel, busy}, {1'b0, 7'h07, 1'b1});
    stop();
    $display("test axis done");
  endtask

  task automatic t_limit();
    start(7'h01, 1'b0);
    @(posedge clk);
    pos_rq <= 1'b1;
    wait_on(3, 16'h0);
    chk({fault_halt, failure_code}, {1'b0, ajc_pkg::CODE_LIMIT});
    wait_on(1, 16'h0);
    stop();
    start(7'h01, 1'b0);
    @(posedge clk);
    neg_rq <= 1'b1;
    wait_on(1, VEL);
    chk({speed_neg, error}, 2'b10);
    stop();
    $display("test limit done");
  endtask

  initial begin
    {rst_n, enable, curve, pos_rq, neg_rq, halt, rel, pwr} = '0;
    {reg_wr, reg_rd, reg_addr, reg_wdata, axis_number} = '0;
    bad_count = 0;
    tests_run = 0;
    vel = VEL;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_refuse();
    t_run(1'b0);
    t_run(1'b1);
    t_both();
    t_abort();
    t_axis();
    t_limit();
    test_done();
  end
endmodule // ajc_jog_command_block_test
